// File: hdl/sbp_defines.svh
// constants of the sector/block protection-bit logic
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH

// register byte offsets
`define SBP_REG_ADDR 8'h00
`define SBP_REG_CMD 8'h04
`define SBP_REG_STATUS 8'h08
`define SBP_REG_CFG 8'h0c
`define SBP_REG_PWD_LO 8'h10
`define SBP_REG_PWD_HI 8'h14
`define SBP_REG_ATT_LO 8'h18
`define SBP_REG_ATT_HI 8'h1c

// command codes, CMD[3:0]; CMD[4] is the dynamic bit value
`define SBP_CMD_PERS_PROG 4'h1
`define SBP_CMD_PERS_ERASE 4'h2
`define SBP_CMD_PERS_READ 4'h3
`define SBP_CMD_DYN_WRITE 4'h4
`define SBP_CMD_DYN_READ 4'h5
`define SBP_LOCK_FLAG_CLEAR_CMD 4'h6
`define SBP_PASSWORD_UNLOCK_CMD 4'h7
`define SBP_CMD_ARRAY_CHECK 4'h8
`define SBP_CMD_SW_RESET 4'h9
`define SBP_CMD_CLR_ERR 4'ha
`define SBP_CMD_DYN_BIT 4

// status fields
`define SBP_ST_BUSY 0
`define SBP_ST_PROG_ERR 1
`define SBP_ST_PROT_ERR 2
`define SBP_ST_LOCK 3
`define SBP_ST_PWD_MODE 4
`define SBP_ST_READ_BIT 5
`define SBP_ST_ALLOWED 6
`define SBP_ST_ARRAY_BLOCK 7

// config fields
`define SBP_CFG_TBSEL 0
`define SBP_CFG_PWD_MODE 1

// layout of the bottom-parameter map
`define SBP_UNITS 286
`define SBP_TOP_BLOCK_FIRST 8'hfe
`define SBP_TOP_UNIT_BASE 9'h0fe

// timing
`define SBP_CLK_PERIOD_NS 10
`define SBP_PERS_PROG_TIME_NS 400000
`define SBP_PERS_ERASE_TIME_NS 50000000
`define SBP_UNLOCK_DELAY_NS 100000

`endif

// File: hdl/sbp_pkg.sv
// types of the sector/block protection-bit logic
package sbp_pkg;
	typedef enum logic [1:0] {SBP_IDLE, SBP_PROG, SBP_ERASE, SBP_UNLOCK_WAIT} sbp_state_e;
	typedef logic [8:0] sbp_unit_t;
	typedef logic [23:0] sbp_addr_t;
endpackage : sbp_pkg

// File: hdl/sbp_unit_map.sv
// byte address to protection unit index, bottom-parameter layout
`timescale 1ns/1ps
`include "sbp_defines.svh"
module sbp_unit_map (
	// address in
	input wire sbp_pkg::sbp_addr_t i_addr,
	// unit index out
	output sbp_pkg::sbp_unit_t o_unit
);
	import sbp_pkg::*;

	// top two 64k blocks split into 4k units; the rest map one block per unit
	always_comb begin
		if (i_addr[23:16] >= `SBP_TOP_BLOCK_FIRST) begin
			o_unit = `SBP_TOP_UNIT_BASE + {4'h0, i_addr[16:12]};
		end else begin
			o_unit = {1'b0, i_addr[23:16]};
		end
	end
endmodule : sbp_unit_map

// File: hdl/sbp_op_timer.sv
// down-counter that times one internal operation
`timescale 1ns/1ps
module sbp_op_timer #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// control
	input wire logic i_start,
	input wire logic [WIDTH-1:0] i_cycles,
	// state
	output logic o_busy,
	output logic o_done
);
	logic [WIDTH-1:0] count;

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			count <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else if (i_start) begin
			count <= i_cycles;
			o_busy <= 1'b1;
			o_done <= 1'b0;
		end else if (o_busy && count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
			count <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b1;
		end else begin
			count <= o_busy ? count - {{(WIDTH-1){1'b0}}, 1'b1} : count;
			o_done <= 1'b0;
		end
	end
endmodule : sbp_op_timer

// File: hdl/sbp_top.sv
// protection-bit logic with a classic wishbone register slave
// Contract
// - bottom layout: blocks 0-253 map to units 0-253, top 4k sectors to 254-285
// - one persistent bit per unit, kept across every reset
// - persistent bits program to 0 singly, erase to 1 all together, no address
// - erase needs no host supervision; device handles it internally
// - program takes a program time, erase an erase time; busy shown meanwhile
// - no array read data while a persistent bit is being programmed
// - persistent-bit read command returns the addressed unit's bit
// - every persistent bit starts erased to 1
// - one volatile dynamic bit per unit, written 0 or 1 freely
// - persistent 0 protects; otherwise the dynamic bit decides
// - lock flag 0 makes persistent program and erase fail
// - persistent mode sets lock at reset; cleared stays cleared until reset
// - password mode clears lock at reset; only a good unlock sets it
// - a command clears the lock flag to 0
// - software reset leaves the lock flag alone
// - wrong password sets program and protection errors, lock stays 0
`timescale 1ns/1ps
`include "sbp_defines.svh"
module sbp_top #(
	parameter int PROG_CYCLES = `SBP_PERS_PROG_TIME_NS / `SBP_CLK_PERIOD_NS,
	parameter int ERASE_CYCLES = `SBP_PERS_ERASE_TIME_NS / `SBP_CLK_PERIOD_NS,
	parameter int UNLOCK_CYCLES = `SBP_UNLOCK_DELAY_NS / `SBP_CLK_PERIOD_NS,
	parameter int UNITS = `SBP_UNITS
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// device state
	output logic o_write_in_progress_flag,
	output logic o_array_read_block
);
	import sbp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// storage

	// non-volatile: values only ever come from the factory state, operations or password/config register writes
	logic [UNITS-1:0] persistent_prot_bit = '1;
	logic [63:0] stored_password = '1;
	logic password_mode = 1'b0;
	// volatile
	logic [UNITS-1:0] dynamic_prot_bit;
	logic lock_flag;
	sbp_addr_t addr;
	logic [63:0] attempt;
	logic top_bottom_param_select;
	logic program_error_flag;
	logic protection_error_flag;
	logic read_bit;
	logic allowed;
	sbp_state_e state;
	sbp_unit_t op_unit;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic bus_req;
	logic wr_en;
	logic cmd_wr;
	logic [3:0] cmd_code;
	logic cmd_dyn_val;
	sbp_unit_t unit;
	logic unit_protected;
	logic pwd_match;

	assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr_en = bus_req && i_wb_we;
	assign cmd_wr = wr_en && (i_wb_adr == `SBP_REG_CMD) && i_wb_sel[0];
	assign cmd_code = i_wb_dat[3:0];
	assign cmd_dyn_val = i_wb_dat[`SBP_CMD_DYN_BIT];

	sbp_unit_map u_map (
		.i_addr(addr),
		.o_unit(unit)
	);

	assign unit_protected = !persistent_prot_bit[unit] || !dynamic_prot_bit[unit];
	assign pwd_match = (attempt == stored_password);

	function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = din[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_lanes

	////////////////////////////////////////////////////////////////////////
	// operation timer

	logic busy;
	logic op_done;
	logic timer_start;
	logic [31:0] timer_cycles;
	logic idle_cmd;

	// commands arriving during an operation are dropped; software polls the busy bit
	assign idle_cmd = cmd_wr && (state == SBP_IDLE) && !busy;

	always_comb begin
		timer_start = 1'b0;
		timer_cycles = 32'h0;
		if (idle_cmd) begin
			unique case (cmd_code)
				`SBP_CMD_PERS_PROG: begin
					timer_start = lock_flag;
					timer_cycles = 32'(PROG_CYCLES);
				end
				`SBP_CMD_PERS_ERASE: begin
					timer_start = lock_flag;
					timer_cycles = 32'(ERASE_CYCLES);
				end
				`SBP_PASSWORD_UNLOCK_CMD: begin
					timer_start = password_mode && !pwd_match;
					timer_cycles = 32'(UNLOCK_CYCLES);
				end
				default: begin
					timer_start = 1'b0;
				end
			endcase
		end
	end

	sbp_op_timer #(
		.WIDTH(32)
	) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_start(timer_start),
		.i_cycles(timer_cycles),
		.o_busy(busy),
		.o_done(op_done)
	);

	////////////////////////////////////////////////////////////////////////
	// operation state

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state <= SBP_IDLE;
			op_unit <= '0;
		end else begin
			unique case (state)
				SBP_IDLE: begin
					if (timer_start) begin
						op_unit <= unit;
						if (cmd_code == `SBP_CMD_PERS_PROG) begin
							state <= SBP_PROG;
						end else if (cmd_code == `SBP_CMD_PERS_ERASE) begin
							state <= SBP_ERASE;
						end else begin
							state <= SBP_UNLOCK_WAIT;
						end
					end
				end
				SBP_PROG, SBP_ERASE, SBP_UNLOCK_WAIT: begin
					if (op_done) begin
						state <= SBP_IDLE;
					end
				end
			endcase
		end
	end

	// hardware reset aborts an operation in flight; the bits keep their old value
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset && op_done && state == SBP_PROG) begin
			persistent_prot_bit[op_unit] <= 1'b0;
		end else if (!i_reset && op_done && state == SBP_ERASE) begin
			persistent_prot_bit <= '1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// dynamic bits

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			dynamic_prot_bit <= '1;
		end else if (idle_cmd && cmd_code == `SBP_CMD_SW_RESET) begin
			dynamic_prot_bit <= '1;
		end else if (idle_cmd && cmd_code == `SBP_CMD_DYN_WRITE) begin
			dynamic_prot_bit[unit] <= cmd_dyn_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock flag

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			lock_flag <= !password_mode;
		end else if (idle_cmd && cmd_code == `SBP_LOCK_FLAG_CLEAR_CMD) begin
			lock_flag <= 1'b0;
		end else if (idle_cmd && cmd_code == `SBP_PASSWORD_UNLOCK_CMD && password_mode && pwd_match) begin
			lock_flag <= 1'b1;
		end
		// software reset has no branch here
	end

	////////////////////////////////////////////////////////////////////////
	// error flags and command results

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			program_error_flag <= 1'b0;
			protection_error_flag <= 1'b0;
		end else if (idle_cmd) begin
			unique case (cmd_code)
				`SBP_CMD_CLR_ERR, `SBP_CMD_SW_RESET: begin
					program_error_flag <= 1'b0;
					protection_error_flag <= 1'b0;
				end
				`SBP_CMD_PERS_PROG, `SBP_CMD_PERS_ERASE: begin
					if (!lock_flag) begin
						program_error_flag <= 1'b1;
						protection_error_flag <= 1'b1;
					end
				end
				`SBP_PASSWORD_UNLOCK_CMD: begin
					if (!password_mode || !pwd_match) begin
						program_error_flag <= 1'b1;
						protection_error_flag <= 1'b1;
					end
				end
				`SBP_CMD_ARRAY_CHECK: begin
					if (unit_protected) begin
						protection_error_flag <= 1'b1;
					end
				end
				default: begin
					program_error_flag <= program_error_flag;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			read_bit <= 1'b1;
			allowed <= 1'b0;
		end else if (idle_cmd && cmd_code == `SBP_CMD_PERS_READ) begin
			read_bit <= persistent_prot_bit[unit];
		end else if (idle_cmd && cmd_code == `SBP_CMD_DYN_READ) begin
			read_bit <= dynamic_prot_bit[unit];
		end else if (idle_cmd && cmd_code == `SBP_CMD_ARRAY_CHECK) begin
			allowed <= !unit_protected;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			addr <= '0;
			attempt <= '0;
			top_bottom_param_select <= 1'b0;
		end else if (wr_en) begin
			unique case (i_wb_adr)
				`SBP_REG_ADDR: begin
					addr <= sbp_addr_t'(merge_lanes({8'h00, addr}, i_wb_dat, i_wb_sel));
				end
				`SBP_REG_ATT_LO: begin
					attempt[31:0] <= merge_lanes(attempt[31:0], i_wb_dat, i_wb_sel);
				end
				`SBP_REG_ATT_HI: begin
					attempt[63:32] <= merge_lanes(attempt[63:32], i_wb_dat, i_wb_sel);
				end
				`SBP_REG_CFG: begin
					if (i_wb_sel[0]) begin
						top_bottom_param_select <= i_wb_dat[`SBP_CFG_TBSEL];
					end
				end
				default: begin
					top_bottom_param_select <= top_bottom_param_select;
				end
			endcase
		end
	end

	// password and mode are one-time: frozen once password mode is chosen
	always_ff @(posedge i_ref_clk) begin
		if (wr_en && !password_mode && !i_reset) begin
			if (i_wb_adr == `SBP_REG_PWD_LO) begin
				stored_password[31:0] <= stored_password[31:0] & merge_lanes(32'hffffffff, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == `SBP_REG_PWD_HI) begin
				stored_password[63:32] <= stored_password[63:32] & merge_lanes(32'hffffffff, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == `SBP_REG_CFG && i_wb_sel[0]) begin
				password_mode <= i_wb_dat[`SBP_CFG_PWD_MODE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux and acknowledge

	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0;
		unique case (i_wb_adr)
			`SBP_REG_ADDR: rd_mux = {8'h00, addr};
			`SBP_REG_STATUS: begin
				rd_mux[`SBP_ST_BUSY] = busy;
				rd_mux[`SBP_ST_PROG_ERR] = program_error_flag;
				rd_mux[`SBP_ST_PROT_ERR] = protection_error_flag;
				rd_mux[`SBP_ST_LOCK] = lock_flag;
				rd_mux[`SBP_ST_PWD_MODE] = password_mode;
				rd_mux[`SBP_ST_READ_BIT] = read_bit;
				rd_mux[`SBP_ST_ALLOWED] = allowed;
				rd_mux[`SBP_ST_ARRAY_BLOCK] = (state == SBP_PROG);
			end
			`SBP_REG_CFG: begin
				rd_mux[`SBP_CFG_TBSEL] = top_bottom_param_select;
				rd_mux[`SBP_CFG_PWD_MODE] = password_mode;
			end
			// password reads back only before the mode is chosen
			`SBP_REG_PWD_LO: rd_mux = password_mode ? 32'h0 : stored_password[31:0];
			`SBP_REG_PWD_HI: rd_mux = password_mode ? 32'h0 : stored_password[63:32];
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= bus_req;
			o_wb_dat <= (bus_req && !i_wb_we) ? rd_mux : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// device state pins

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_write_in_progress_flag <= 1'b0;
			o_array_read_block <= 1'b0;
		end else begin
			o_write_in_progress_flag <= timer_start || (busy && !op_done);
			o_array_read_block <= (timer_start && cmd_code == `SBP_CMD_PERS_PROG)
				|| (state == SBP_PROG && !op_done);
		end
	end
endmodule : sbp_top

// File: test/sbp_host_model.sv
// wishbone master standing in for the serial host controller
`timescale 1ns/1ps
module sbp_host_model (
	// clock
	input wire logic i_ref_clk,
	// answer from the block
	input wire logic [31:0] i_wb_dat,
	input wire logic i_wb_ack,
	// request to the block
	output logic o_wb_cyc,
	output logic o_wb_stb,
	output logic o_wb_we,
	output logic [7:0] o_wb_adr,
	output logic [31:0] o_wb_dat,
	output logic [3:0] o_wb_sel
);
	int stalls = 0;
	initial begin
		o_wb_cyc = 1'b0;
		o_wb_stb = 1'b0;
		o_wb_we = 1'b0;
		o_wb_adr = 8'h00;
		o_wb_dat = 32'h0;
		o_wb_sel = 4'h0;
	end
	// one classic cycle, entered just after a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we <= w;
		o_wb_adr <= a;
		o_wb_dat <= d;
		o_wb_sel <= 4'hf;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (i_wb_ack !== 1'b1 && n < 50);
		if (i_wb_ack !== 1'b1) begin
			stalls++;
		end
		r = i_wb_dat;
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		// released address and data lines never keep the old value
		o_wb_adr <= ~a;
		o_wb_dat <= ~d;
		@(posedge i_ref_clk);
	endtask : xfer
endmodule : sbp_host_model

// File: test/sbp_top_sva.sv
// assertions on the ports of the protection-bit block
`timescale 1ns/1ps
module sbp_top_sva #(
	parameter int PROG_CYCLES = 5,
	parameter int ERASE_CYCLES = 8,
	parameter int UNLOCK_CYCLES = 6,
	parameter int UNITS = 286
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// wishbone
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// device state
	input wire logic o_write_in_progress_flag,
	input wire logic o_array_read_block
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);
	logic cmd_wr;
	int blk_cnt;
	int busy_cnt;
	assign cmd_wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == 8'h04;
	// run lengths kept in counters, too long for repetition
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !o_array_read_block) begin
			blk_cnt <= 0;
		end else begin
			blk_cnt <= blk_cnt + 1;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !o_write_in_progress_flag) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	a_ack_after_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("no ack one cycle after a request");
	a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data outside ack");
	a_reset_quiet: assert property ($fell(i_reset) |-> !o_wb_ack && !o_write_in_progress_flag && !o_array_read_block)
		else $error("outputs not idle after reset");
	a_block_in_busy: assert property (o_array_read_block |-> o_write_in_progress_flag)
		else $error("array blocked while not busy");
	a_busy_from_cmd: assert property ($rose(o_write_in_progress_flag) |-> $past(cmd_wr) || $past(cmd_wr, 2))
		else $error("busy without a command");
	a_prog_length: assert property ($fell(o_array_read_block) |-> blk_cnt >= PROG_CYCLES - 1 && blk_cnt <= PROG_CYCLES + 2)
		else $error("program time wrong");
	a_busy_bounded: assert property (busy_cnt <= ERASE_CYCLES + PROG_CYCLES + UNLOCK_CYCLES + 4)
		else $error("busy never ends");
endmodule : sbp_top_sva
bind sbp_top sbp_top_sva #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES), .UNLOCK_CYCLES(UNLOCK_CYCLES),
	.UNITS(UNITS)) i_sva (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack), .o_write_in_progress_flag(o_write_in_progress_flag),
	.o_array_read_block(o_array_read_block));

// File: test/tb_top.sv
// self-checking bench of the protection-bit block
`timescale 1ns/1ps
module tb_top;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [31:0] wdat;
	logic [3:0] sel;
	logic [31:0] rdat;
	logic ack;
	logic busy_out;
	logic blk;
	int mismatches = 0;
	int n_compared = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	sbp_top #(.PROG_CYCLES(5), .ERASE_CYCLES(8), .UNLOCK_CYCLES(6), .UNITS(286)) i_dut (.i_ref_clk(i_ref_clk),
		.i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .o_write_in_progress_flag(busy_out),
		.o_array_read_block(blk));
	sbp_host_model i_host (.i_ref_clk(i_ref_clk), .i_wb_dat(rdat), .i_wb_ack(ack), .o_wb_cyc(cyc),
		.o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_dat(wdat), .o_wb_sel(sel));
	////////////////////////////////////////////////////////////////
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		i_host.xfer(w, a, d, r);
		if (i_host.stalls != 0) begin
			mismatches++;
			end_sim();
		end
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	// polls status until idle; the bound stands in for a hang
	task idle(output logic [31:0] s);
		int n;
		n = 0;
		do begin
			bus(1'b0, 8'h08, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 60);
		if (s[0] !== 1'b0) begin
			mismatches++;
			end_sim();
		end
	endtask : idle
	task op(input logic [23:0] a, input logic [3:0] c, input logic v, output logic [31:0] s);
		wr(8'h00, {8'h00, a});
		wr(8'h04, {27'h0, v, c});
		idle(s);
	endtask : op
	task hrst;
		i_reset <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		@(posedge i_ref_clk);
	endtask : hrst
	function automatic int unit_of(input logic [23:0] a);
		return (a[23:16] < 8'hfe) ? int'(a[23:16]) : 254 + int'(a[16:12]);
	endfunction : unit_of
	// first byte of the unit, unused low bits zero
	function automatic logic [23:0] base_of(input logic [23:0] a);
		return (a[23:16] < 8'hfe) ? {a[23:16], 16'h0} : {a[23:12], 12'h0};
	endfunction : base_of
	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] s;
		logic [23:0] a;
		logic [23:0] b;
		void'($urandom(32'hea1f));
		repeat (10) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		@(posedge i_ref_clk);
		bus(1'b0, 8'h08, 32'h0, s);
		chk(s & 32'h1f, 32'h08);
		bus(1'b0, 8'h20, 32'h0, s);
		chk(s, 32'h0);
		wr(8'h0c, 32'h1);
		bus(1'b0, 8'h0c, 32'h0, s);
		chk(s, 32'h1);
		wr(8'h0c, 32'h0);
		$display("reset state done");
		wr(8'h00, 32'h00abc000);
		wr(8'h04, 32'h1);
		bus(1'b0, 8'h08, 32'h0, s);
		chk({s[7], s[0], blk, busy_out}, 4'hf);
		idle(s);
		op(24'h0, 4'h2, 1'b0, s);
		op(24'habc000, 4'h3, 1'b0, s);
		chk(s[5], 1'b1);
		// random pairs; top sectors and the block edge forced
		for (int i = 0; i < 6; i++) begin
			a = 24'($urandom);
			if (i < 2) a[23:17] = 7'h7f;
			b = (i % 2) ? {a[23:12], 12'($urandom)} : ((i == 2) ? a ^ 24'h001000 : 24'($urandom));
			if (i == 5) a = 24'hfdffff;
			if (i == 5) b = 24'hfe0000;
			op(a, 4'h1, 1'b0, s);
			chk(s[2:0], 3'h0);
			op(base_of(b), 4'h3, 1'b0, s);
			chk(s[5], unit_of(a) != unit_of(b));
			op(b, 4'h8, 1'b0, s);
			chk(s[6], unit_of(a) != unit_of(b));
			op(b, 4'ha, 1'b0, s);
			op(b, 4'h2, 1'b0, s);
			op(base_of(a), 4'h3, 1'b0, s);
			chk(s[5], 1'b1);
		end
		$display("mapping done");
		a = 24'h123456;
		op(a, 4'h4, 1'b0, s);
		op(a, 4'h5, 1'b0, s);
		chk(s[5], 1'b0);
		op(a, 4'h8, 1'b0, s);
		chk({s[6], s[2]}, 2'h1);
		op(a, 4'ha, 1'b0, s);
		op(a, 4'h4, 1'b1, s);
		op(a, 4'h8, 1'b0, s);
		chk(s[6:1], 6'h24);
		op(a, 4'h4, 1'b0, s);
		hrst();
		op(a, 4'h5, 1'b0, s);
		chk(s[5], 1'b1);
		$display("dynamic bits done");
		op(a, 4'h1, 1'b0, s);
		// bits settled before the lock drops
		op(a, 4'h6, 1'b0, s);
		chk(s[3], 1'b0);
		op(a, 4'h7, 1'b0, s);
		chk(s[3], 1'b0);
		op(24'h200000, 4'h1, 1'b0, s);
		chk(s[3:1], 3'h3);
		op(24'h200000, 4'h3, 1'b0, s);
		chk(s[5], 1'b1);
		op(a, 4'h9, 1'b0, s);
		chk(s[3:1], 3'h0);
		hrst();
		op(base_of(a), 4'h3, 1'b0, s);
		chk(s[5:3], 3'h1);
		op(a, 4'h2, 1'b0, s);
		$display("lock done");
		wr(8'h0c, 32'h2);
		hrst();
		wr(8'h18, 32'h0);
		wr(8'h1c, 32'h0);
		bus(1'b0, 8'h08, 32'h0, s);
		chk(s[4:3], 2'h2);
		wr(8'h04, 32'h7);
		idle(s);
		chk(s[3:1], 3'h3);
		op(a, 4'ha, 1'b0, s);
		wr(8'h18, 32'hffffffff);
		wr(8'h1c, 32'hffffffff);
		wr(8'h04, 32'h7);
		idle(s);
		chk(s[3:1], 3'h4);
		$display("password done");
		end_sim();
	end
endmodule : tb_top
